// ==== tcps_defs.vh ====
`ifndef TCPS_DEFS_VH
`define TCPS_DEFS_VH

// register word index on the avalon slave
`define TCPS_ADDR_W        2
`define TCPS_REG_CONTROL   2'h0
`define TCPS_REG_COUNT_LO  2'h1
`define TCPS_REG_COUNT_HI  2'h2
`define TCPS_REG_IRQ_CTRL  2'h3

// timer_control fields
`define TCPS_CTL_RUN       7
`define TCPS_CTL_NARROW    6
`define TCPS_CTL_SOURCE    5
`define TCPS_CTL_EDGE      4
`define TCPS_CTL_BYPASS    3
`define TCPS_CTL_RATIO_HI  2
`define TCPS_CTL_RATIO_LO  0

// interrupt_control fields
`define TCPS_IRQ_ENABLE    5
`define TCPS_IRQ_FLAG      2

// reset values and all-ones constants
`define TCPS_CONTROL_RST   8'hFF
`define TCPS_BYTE_ZERO     8'h00
`define TCPS_WORD_ZERO     16'h0000
`define TCPS_READ_ZERO     32'h00000000
`define TCPS_PRE_ZERO      8'h00
`define TCPS_BYTE_ONES     8'hFF
`define TCPS_WORD_ONES     16'hFFFF

// timing
`define TCPS_CORE_CLK_HZ   10000000
`define TCPS_INSTR_DIV     4
`define TCPS_DIV_W         2
`define TCPS_INHIBIT_TICKS 2'h2
`define TCPS_INHIBIT_W     2

`endif

// ==== tcps_timer.v ====

`include "tcps_defs.vh"

module tcps_timer
#(
    parameter INSTR_DIV = `TCPS_INSTR_DIV
)
(
    input  wire        core_clk_in,          // 10 MHz core clock
    input  wire        rst_n_in,             // async reset, active low
    input  wire [1:0]  avs_address_in,       // register word index
    input  wire        avs_read_in,          // avalon read request
    input  wire        avs_write_in,         // avalon write request
    input  wire [31:0] avs_writedata_in,     // avalon write data
    input  wire [3:0]  avs_byteenable_in,    // avalon byte enables
    input  wire        sleep_in,             // core asleep, same clock domain
    input  wire        ext_count_in,         // external count pin, async
    output wire [31:0] avs_readdata_out,     // avalon read data
    output wire        avs_waitrequest_out,  // avalon wait request
    output wire        overflow_irq_out      // overflow interrupt request
);

    // mask of prescaler bits that must wrap to give one output event
    function [7:0] tcps_ratio_mask;
        input [2:0] ratio;
        begin
            tcps_ratio_mask = (`TCPS_BYTE_ONES >> (3'h7 - ratio));
        end
    endfunction

    reg  [7:0]  control_r;
    reg  [15:0] count_r;
    reg  [7:0]  high_buf_r;
    reg         irq_en_r;
    reg         flag_r;
    reg  [7:0]  pre_r;
    reg  [`TCPS_INHIBIT_W-1:0] inhibit_r;
    reg  [`TCPS_DIV_W-1:0]     div_r;
    reg         ext_meta_r;
    reg         ext_sync_r;
    reg         ext_prev_r;
    reg         wait_r;
    reg  [31:0] rdata_r;
    reg         irq_r;

    wire        run_enable          = control_r[`TCPS_CTL_RUN];
    wire        narrow_width_select = control_r[`TCPS_CTL_NARROW];
    wire        count_source_select = control_r[`TCPS_CTL_SOURCE];
    wire        count_edge_select   = control_r[`TCPS_CTL_EDGE];
    wire        prescaler_bypass    = control_r[`TCPS_CTL_BYPASS];
    wire [2:0]  prescale_ratio      = control_r[`TCPS_CTL_RATIO_HI:`TCPS_CTL_RATIO_LO];

    wire        req       = avs_read_in | avs_write_in;
    wire        wr_accept = avs_write_in & ~wait_r & avs_byteenable_in[0];
    wire        rd_first  = avs_read_in & wait_r;
    wire        wr_ctrl   = wr_accept & (avs_address_in == `TCPS_REG_CONTROL);
    wire        wr_low    = wr_accept & (avs_address_in == `TCPS_REG_COUNT_LO);
    wire        wr_high   = wr_accept & (avs_address_in == `TCPS_REG_COUNT_HI);
    wire        wr_irq    = wr_accept & (avs_address_in == `TCPS_REG_IRQ_CTRL);
    wire        rd_low    = rd_first & (avs_address_in == `TCPS_REG_COUNT_LO);
    wire [7:0]  wbyte     = avs_writedata_in[7:0];

    // one tick per instruction cycle
    wire        instr_tick = (div_r == INSTR_DIV - 1);

    // edges seen only after the two synchroniser stages
    wire        ext_rise  = ext_sync_r & ~ext_prev_r;
    wire        ext_fall  = ~ext_sync_r & ext_prev_r;
    wire        ext_edge  = count_edge_select ? ext_fall : ext_rise;

    // the timer is frozen while stopped, asleep, or after a count write
    wire        active    = run_enable & ~sleep_in & (inhibit_r == 0);
    wire        src_ev    = active & (count_source_select ? ext_edge
                                                          : instr_tick);
    wire [7:0]  pre_nxt   = pre_r + 8'h01;
    wire        pre_ev    = src_ev &
                            ((pre_nxt & tcps_ratio_mask(prescale_ratio)) == 0);
    // bypass is read live, so reassignment takes hold on the next event
    wire        cnt_ev    = prescaler_bypass ? src_ev : pre_ev;

    wire        wrap8     = (count_r[7:0] == `TCPS_BYTE_ONES);
    wire        wrap16    = (count_r == `TCPS_WORD_ONES);
    wire        overflow  = cnt_ev & (narrow_width_select ? wrap8 : wrap16);

    reg  [15:0] count_nxt;
    reg  [31:0] rdata_nxt;

    always @*
    begin
        count_nxt = count_r;
        if (wr_low)
        begin
            count_nxt[7:0] = wbyte;
            if (!narrow_width_select)
            begin
                count_nxt[15:8] = high_buf_r;
            end
        end
        else if (cnt_ev)
        begin
            if (narrow_width_select)
            begin
                count_nxt[7:0] = count_r[7:0] + 8'h01;
            end
            else
            begin
                count_nxt = count_r + 16'h0001;
            end
        end
    end

    always @*
    begin
        rdata_nxt = `TCPS_READ_ZERO;
        case (avs_address_in)
            `TCPS_REG_CONTROL:  rdata_nxt[7:0] = control_r;
            `TCPS_REG_COUNT_LO: rdata_nxt[7:0] = count_r[7:0];
            `TCPS_REG_COUNT_HI: rdata_nxt[7:0] = high_buf_r;
            `TCPS_REG_IRQ_CTRL:
            begin
                rdata_nxt[`TCPS_IRQ_ENABLE] = irq_en_r;
                rdata_nxt[`TCPS_IRQ_FLAG]   = flag_r;
            end
            default:            rdata_nxt = `TCPS_READ_ZERO;
        endcase
    end

    // avalon handshake: every access waits exactly one cycle
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_r  <= 1'b1;
            rdata_r <= `TCPS_READ_ZERO;
        end
        else
        begin
            if (req && wait_r)
            begin
                wait_r <= 1'b0;
            end
            else
            begin
                wait_r <= 1'b1;
            end
            if (rd_first)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end
        else
        begin
            ext_meta_r <= ext_count_in;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_r <= {`TCPS_DIV_W{1'b0}};
        end
        else if (instr_tick)
        begin
            div_r <= {`TCPS_DIV_W{1'b0}};
        end
        else
        begin
            div_r <= div_r + 1'b1;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            inhibit_r <= {`TCPS_INHIBIT_W{1'b0}};
        end
        else if (wr_low)
        begin
            inhibit_r <= `TCPS_INHIBIT_TICKS;
        end
        else if (instr_tick && inhibit_r != 0)
        begin
            inhibit_r <= inhibit_r - 1'b1;
        end
    end

    // hidden prescaler: no address reads it; a count write clears it unless bypassed
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pre_r <= `TCPS_PRE_ZERO;
        end
        else if (wr_low && !prescaler_bypass)
        begin
            pre_r <= `TCPS_PRE_ZERO;
        end
        else if (src_ev && !prescaler_bypass)
        begin
            pre_r <= pre_nxt;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            control_r  <= `TCPS_CONTROL_RST;
            count_r    <= `TCPS_WORD_ZERO;
            high_buf_r <= `TCPS_BYTE_ZERO;
            irq_en_r   <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            // a count write never touches the assignment bit
            if (wr_ctrl)
            begin
                control_r <= wbyte;
            end
            if (wr_high)
            begin
                high_buf_r <= wbyte;
            end
            else if (rd_low && !narrow_width_select)
            begin
                high_buf_r <= count_r[15:8];
            end
            if (wr_irq)
            begin
                irq_en_r <= wbyte[`TCPS_IRQ_ENABLE];
            end
        end
    end

    // set wins over a software clear in the same cycle
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            flag_r <= 1'b0;
        end
        else if (overflow)
        begin
            flag_r <= 1'b1;
        end
        else if (wr_irq)
        begin
            flag_r <= wbyte[`TCPS_IRQ_FLAG];
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= flag_r & irq_en_r;
        end
    end

    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign overflow_irq_out    = irq_r;

endmodule // tcps_timer

// ==== tcps_timer_monitor.sv ====
`include "tcps_defs.vh"
module tcps_timer_monitor (
    input wire logic        core_clk_in,          // clock
    input wire logic        rst_n_in,             // reset
    input wire logic [1:0]  avs_address_in,       // index
    input wire logic        avs_read_in,          // read
    input wire logic        avs_write_in,         // write
    input wire logic [31:0] avs_writedata_in,     // wdata
    input wire logic [3:0]  avs_byteenable_in,    // lanes
    input wire logic [31:0] avs_readdata_out,     // rdata
    input wire logic        avs_waitrequest_out,  // wait
    input wire logic        overflow_irq_out      // irq
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] ctl_r;
    logic       en_r;
    wire        acc_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    // shadows follow accepted writes only, so reads are judged without the body
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctl_r <= 8'hFF;
            en_r  <= 1'b0;
        end
        else if (acc_wr && avs_address_in == 2'h0)
            ctl_r <= avs_writedata_in[7:0];
        else if (acc_wr && avs_address_in == 2'h3)
            en_r <= avs_writedata_in[5];
    end
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_mask;
        acc_wr && avs_address_in == 2'h3 && !avs_writedata_in[5];
    endsequence
    chk_wait_one: assert property (s_req |=> !avs_waitrequest_out)
        else $error("request not answered after one wait cycle");
    chk_wait_back: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait request low for more than one cycle");
    chk_idle_wait: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
        else $error("answer without request");
    chk_ctl_read: assert property (!avs_waitrequest_out && avs_read_in && avs_address_in == 2'h0
        |-> avs_readdata_out[7:0] == ctl_r)
        else $error("control read differs from written value");
    chk_rd_upper: assert property (avs_readdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_rd_hold: assert property (!avs_read_in |=> $stable(avs_readdata_out))
        else $error("read data moved without a read");
    chk_irq_mask: assert property (overflow_irq_out |-> $past(en_r))
        else $error("irq raised while disabled");
    chk_irq_off: assert property (s_mask |-> ##2 !overflow_irq_out)
        else $error("irq not masked two cycles after disable");
    chk_flag_hold: assert property ($fell(overflow_irq_out)
        |-> $past(acc_wr && avs_address_in == 2'h3, 2))
        else $error("irq dropped without a software write");
endmodule // tcps_timer_monitor
bind tcps_timer tcps_timer_monitor mon_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .overflow_irq_out(overflow_irq_out));

// ==== tcps_timer_tb_top.sv ====
`include "tcps_defs.vh"
module tcps_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, slp = 1'b0, ext = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  be = 4'hF;
    logic [7:0]  v, a, b;
    wire  [31:0] rdata;
    wire         wait_q, irq;
    int          errors = 0, checked = 0;
    always #50 clk = ~clk;
    tcps_timer dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .sleep_in(slp), .ext_count_in(ext),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_q), .overflow_irq_out(irq));
    task automatic give_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] ad, input logic [7:0] d,
                       output logic [7:0] q);
        int n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= ad;
        wdata <= {24'h000000, d};
        @(posedge clk);
        while (wait_q !== 1'b0)
        begin
            n++;
            if (n > 50)
            begin
                errors++;
                give_verdict();
            end
            @(posedge clk);
        end
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // counts over a window that is a whole number of periods, so tick phase drops out
    task automatic rate(input logic [7:0] c, input logic s, input int gap, input logic [7:0] e);
        bus(1'b1, 2'h0, c, v);
        slp <= s;
        bus(1'b0, 2'h1, 8'h00, a);
        repeat (gap - 3) @(posedge clk);
        bus(1'b0, 2'h1, 8'h00, b);
        slp <= 1'b0;
        cmp("count step", e, b - a);
    endtask
    task automatic ext_cnt(input logic [7:0] c, input logic [7:0] e);
        bus(1'b1, 2'h0, c, v);
        bus(1'b1, 2'h1, 8'h00, v);
        repeat (12) @(posedge clk);
        repeat (6)
        begin
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        bus(1'b0, 2'h1, 8'h00, a);
        cmp("edge count", e, a);
        bus(1'b0, 2'h0, 8'h00, v);
        cmp("assignment kept", c, v);
    endtask
    task automatic reset_vals();
        bus(1'b0, 2'h0, 8'h00, v);
        cmp("control reset", 8'hFF, v);
        bus(1'b0, 2'h2, 8'h00, v);
        cmp("buffer reset", 8'h00, v);
        be <= 4'h0;
        bus(1'b1, 2'h0, 8'h00, v);
        be <= 4'hF;
        bus(1'b0, 2'h0, 8'h00, v);
        cmp("lane off write", 8'hFF, v);
    endtask
    task automatic inhibit();
        bus(1'b1, 2'h0, 8'hC8, v);
        bus(1'b1, 2'h1, 8'h40, v);
        repeat (79) @(posedge clk);
        bus(1'b0, 2'h1, 8'h00, a);
        cmp("after write", 8'h52, a);
    endtask
    task automatic wrap(input logic [7:0] c, input logic [7:0] hb);
        bus(1'b1, 2'h3, 8'h00, v);
        bus(1'b1, 2'h0, c, v);
        bus(1'b1, 2'h2, 8'hFF, v);
        bus(1'b1, 2'h1, 8'hF0, v);
        repeat (99) @(posedge clk);
        bus(1'b0, 2'h1, 8'h00, a);
        bus(1'b0, 2'h2, 8'h00, b);
        cmp("wrap low", 8'h07, a);
        cmp("wrap high", hb, b);
        bus(1'b0, 2'h3, 8'h00, v);
        cmp("wrap flag", 8'h04, v & 8'h24);
    endtask
    task automatic irq_chk();
        bus(1'b1, 2'h0, 8'h48, v);
        bus(1'b1, 2'h3, 8'h24, v);
        repeat (3) @(posedge clk);
        cmp("irq on", 8'h01, {7'h00, irq});
        bus(1'b1, 2'h3, 8'h04, v);
        repeat (3) @(posedge clk);
        cmp("irq masked", 8'h00, {7'h00, irq});
        repeat (200) @(posedge clk);
        bus(1'b0, 2'h3, 8'h00, v);
        cmp("flag held", 8'h04, v & 8'h24);
        bus(1'b1, 2'h3, 8'h20, v);
        bus(1'b0, 2'h3, 8'h00, v);
        cmp("flag cleared", 8'h20, v & 8'h24);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        reset_vals();
        rate(8'hC8, 1'b0, 80, 8'd20);
        rate(8'h48, 1'b0, 80, 8'd0);
        rate(8'hC8, 1'b1, 80, 8'd0);
        for (int r = 0; r < 8; r++)
            rate(8'hC0 | r[7:0], 1'b0, 8 << (r + 1), 8'd2);
        inhibit();
        ext_cnt(8'hE8, 8'd6);
        ext_cnt(8'hF8, 8'd6);
        ext_cnt(8'hE0, 8'd3);
        wrap(8'h88, 8'h00);
        wrap(8'hC8, 8'hFF);
        irq_chk();
        give_verdict();
    end
endmodule // tcps_timer_tb_top
